// file: hdl/bridge_pin_function_select.sv
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
// Function
// [RQ1] cpu-style fifo mode selected by configuration
// [RQ2] low byte is shared bidirectional data bus
// [RQ3] processor qualifies accesses with chip select
// [RQ4] processor drives register select, read, write strobes
// [RQ5] half-duplex slave mode enabled by configuration
// [RQ6] slave bus width 1,2,4,8; one direction
// [RQ7] line n carries bit n of command/data
// [RQ8] master supplies serial clock; transfers follow it
// [RQ9] master frames transactions with slave select
// [RQ10] status output shows tx empty, rx full
// [RQ11] eleven auxiliary pins, each separately assignable
// [RQ12] option: rs485 transmit enable while sending
// [RQ13] options: power enable low, suspend low
// [RQ14] options: active-low tx, rx, traffic indicators
// [RQ15] options: 30, 15, 7.5 MHz clock outputs; from the 100 MHz core clock the code gives 50, 16.7, 8.3 MHz
// [RQ16] options: pulled-up input, drive high, drive low
// [RQ17] gpio per pin; pins 5,6,8,9 during serial
// [RQ18] one option per pin from configuration bits
// [RQ19] power enable high in suspend, low otherwise
// [RQ20] configuration loaded after reset, then frozen
module bridge_pin_function_select
  import bridge_pkg::*;
(
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          srst,
  // configuration memory contents
  input  wire logic [1:0]                    cfgMode,
  input  wire logic [1:0]                    cfgWidth,
  input  wire logic [AUX_PINS*OPT_W-1:0]     cfgAux,
  // user-side byte exchange
  input  wire logic [7:0]                    txData,
  input  wire logic                          txLoad,
  output logic                               txEmpty,
  output logic [7:0]                         rxData,
  output logic                               rxFull,
  input  wire logic                          rxTake,
  // chip state
  input  wire logic                          uartSending,
  input  wire logic                          usbSuspend,
  // auxiliary pins
  input  wire logic [AUX_PINS-1:0]           auxiliaryPinBusIn,
  output logic [AUX_PINS-1:0]                auxiliaryPinBusOut,
  output logic [AUX_PINS-1:0]                auxiliaryPinBusOe,
  output logic [AUX_PINS-1:0]                auxiliaryPinBusPullup,
  // bit-bang control
  input  wire logic [AUX_PINS-1:0]           gpioOut,
  input  wire logic [AUX_PINS-1:0]           gpioOe,
  output logic [AUX_PINS-1:0]                gpioIn,
  // link to the processor or master
  bridge_pins_if.device                      pins
);
  import bridge_pkg::*;

  mode_t                      mode;
  logic [1:0]                 width;
  logic [AUX_PINS*OPT_W-1:0]  auxCfg;
  logic                       loaded;
  logic [7:0]                 txHold;
  logic                       csPrev;
  logic                       selPrev;
  logic                       rdPrev;
  logic                       wrPrev;
  logic                       sclkPrev;
  logic [7:0]                 cpuOut;
  logic [3:0]                 beat;
  logic                       inCmd;
  logic                       cmdRead;
  logic [7:0]                 shiftReg;
  logic [7:0]                 hdOut;
  logic                       hdOe;
  logic [7:0]                 next_shift;
  logic                       isCpu;
  logic                       isHd;
  logic                       cpuWrDone;
  logic                       cpuRdDone;
  logic                       sclkRise;
  logic                       sclkFall;
  logic                       lastBeat;
  logic                       hdWrDone;
  logic                       hdRdDone;
  logic                       txPop;
  logic                       rxGot;
  logic [7:0]                 rxByte;
  logic                       txEvent;
  logic                       rxEvent;
  logic [15:0]                txStretch;
  logic [15:0]                rxStretch;
  logic [2:0]                 clkOut;
  logic [7:0]                 clkCnt [3];
  logic [7:0]                 clkHalf [3];

  // capture the configuration once after reset; nothing re-reads it later
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      loaded <= 1'b0;
      mode   <= MODE_SERIAL;
      width  <= 2'h0;
      auxCfg <= '0;
    end
    else if (!loaded)
    begin
      loaded <= 1'b1;                               // RQ20
      mode   <= mode_t'(cfgMode);                   // RQ1 RQ5
      width  <= cfgWidth;                           // RQ6
      auxCfg <= cfgAux;                             // RQ18
    end
  end

  assign isCpu = loaded && (mode == MODE_CPU_FIFO);     // RQ1
  assign isHd  = loaded && (mode == MODE_HALF_DUPLEX);  // RQ5

  // previous pin levels for edge detection (pins are synchronous)
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      csPrev   <= 1'b1;
      selPrev  <= 1'b0;
      rdPrev   <= 1'b1;
      wrPrev   <= 1'b1;
      sclkPrev <= 1'b0;
    end
    else
    begin
      csPrev   <= pins.chipSelect_n;
      selPrev  <= pins.registerSelectBit;
      rdPrev   <= pins.readStrobe_n;
      wrPrev   <= pins.writeStrobe_n;
      sclkPrev <= pins.serialClock;
    end
  end

  // strobe ends count only while chip select was held low
  assign cpuWrDone = isCpu && !csPrev && !wrPrev && pins.writeStrobe_n;   // RQ3 RQ4
  assign cpuRdDone = isCpu && !csPrev && !rdPrev && pins.readStrobe_n;    // RQ3 RQ4
  assign sclkRise  = isHd && !pins.slaveSelect_n && pins.serialClock && !sclkPrev;  // RQ8 RQ9
  assign sclkFall  = isHd && !pins.slaveSelect_n && !pins.serialClock && sclkPrev;  // RQ8
  assign lastBeat  = (beat == beatsOf(width) - 4'h1);
  assign next_shift = shiftIn(shiftReg, pins.lowDataPins, width);   // RQ7
  assign hdWrDone  = sclkRise && !inCmd && lastBeat && !cmdRead;
  assign hdRdDone  = sclkRise && !inCmd && lastBeat && cmdRead;

  // cpu read data: register select high gives the status byte
  always_ff @(posedge clock)
  begin
    if (srst)
      cpuOut <= 8'h00;
    else if (pins.registerSelectBit)
      cpuOut <= 8'((rxFull << ST_RX_FULL) | (txEmpty << ST_TX_EMPTY));
    else
      cpuOut <= txHold;
  end

  // half-duplex framing: command byte first, then one data byte
  always_ff @(posedge clock)
  begin
    if (srst || !isHd || pins.slaveSelect_n)
    begin
      beat     <= 4'h0;                             // RQ9
      inCmd    <= 1'b1;
      hdOe     <= 1'b0;
      hdOut    <= 8'h00;
      shiftReg <= 8'h00;
      if (srst)
        cmdRead <= 1'b0;
    end
    else if (sclkRise)
    begin
      shiftReg <= next_shift;                       // RQ7
      beat     <= lastBeat ? 4'h0 : 4'(beat + 4'h1);
      if (inCmd && lastBeat)
      begin
        inCmd   <= 1'b0;
        cmdRead <= next_shift[0];
      end
    end
    else if (sclkFall && !inCmd && cmdRead)
    begin
      hdOe  <= 1'b1;                                // RQ6
      hdOut <= (beat == 4'h0) ? txHold : 8'(hdOut >> (4'(1 << width)));
    end
  end

  // the device drives only the lines in use, only when it is its turn
  always_comb
  begin
    pins.devData   = isCpu ? cpuOut : hdOut;
    pins.devDataOe = 8'h00;
    if (isCpu && !pins.chipSelect_n && !pins.readStrobe_n)
      pins.devDataOe = 8'hFF;                       // RQ2
    else if (hdOe)
      pins.devDataOe = laneMask(width);             // RQ6
  end

  // one pin tells one buffer state, chosen by the last half-duplex command; rx full in cpu mode
  assign pins.statusLine = cmdRead ? txEmpty : rxFull;   // RQ10

  assign txPop   = !txEmpty && ((cpuRdDone && !selPrev) || hdRdDone);
  assign rxGot   = (cpuWrDone && !selPrev) || hdWrDone;
  assign rxByte  = isCpu ? pins.lowDataPins : next_shift;   // RQ2
  assign txEvent = txPop;
  assign rxEvent = rxGot && !rxFull;

  // one-byte holding registers; set wins over clear
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      txHold  <= 8'h00;
      txEmpty <= 1'b1;
      rxData  <= 8'h00;
      rxFull  <= 1'b0;
    end
    else
    begin
      if (txLoad && txEmpty)
        txHold <= txData;
      if (txPop)
        txEmpty <= 1'b1;
      else if (txLoad)
        txEmpty <= 1'b0;
      if (rxGot && !rxFull)
        rxData <= rxByte;                           // a byte sent to a full buffer is dropped
      if (rxGot)
        rxFull <= 1'b1;
      else if (rxTake)
        rxFull <= 1'b0;
    end
  end

  // stretch each traffic event so an indicator is visible
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      txStretch <= 16'h0000;
      rxStretch <= 16'h0000;
    end
    else
    begin
      txStretch <= txEvent ? 16'(INDICATOR_CYCLES) : (txStretch != 16'h0000 ? 16'(txStretch - 16'h0001) : 16'h0000);
      rxStretch <= rxEvent ? 16'(INDICATOR_CYCLES) : (rxStretch != 16'h0000 ? 16'(rxStretch - 16'h0001) : 16'h0000);
    end
  end

  // free-running clock outputs; each half period is rounded down to a whole number of core clock cycles
  assign clkHalf[0] = 8'(HALF30);
  assign clkHalf[1] = 8'(HALF15);
  assign clkHalf[2] = 8'(HALF7);
  always_ff @(posedge clock)
  begin
    for (int k = 0; k < 3; k++)
    begin
      if (srst)
      begin
        clkCnt[k] <= 8'h00;
        clkOut[k] <= 1'b0;
      end
      else if (clkCnt[k] == clkHalf[k] - 8'h01)
      begin
        clkCnt[k] <= 8'h00;
        clkOut[k] <= !clkOut[k];                    // RQ15
      end
      else
        clkCnt[k] <= 8'(clkCnt[k] + 8'h01);
    end
  end

  // bit-bang inputs are registered so the user sees a clean level
  always_ff @(posedge clock)
  begin
    if (srst)
      gpioIn <= '0;
    else
      gpioIn <= auxiliaryPinBusIn;                  // RQ17
  end

  // per-pin function select; unloaded pins stay pulled-up inputs
  always_comb
  begin
    for (int i = 0; i < AUX_PINS; i++)
    begin
      auxiliaryPinBusOut[i]    = 1'b0;
      auxiliaryPinBusOe[i]     = loaded;            // RQ11
      auxiliaryPinBusPullup[i] = 1'b0;
      case (aux_opt_t'(auxCfg[i*OPT_W +: OPT_W]))   // RQ18
        OPT_DRIVE_HIGH:           auxiliaryPinBusOut[i] = 1'b1;            // RQ16
        OPT_DRIVE_LOW:            auxiliaryPinBusOut[i] = 1'b0;            // RQ16
        OPT_RS485_TX_ENABLE:      auxiliaryPinBusOut[i] = uartSending;     // RQ12
        OPT_POWER_ENABLE_N:       auxiliaryPinBusOut[i] = usbSuspend;      // RQ13 RQ19
        OPT_SUSPEND_N:            auxiliaryPinBusOut[i] = !usbSuspend;     // RQ13
        OPT_TRANSMIT_INDICATOR_N: auxiliaryPinBusOut[i] = txStretch == 16'h0000;   // RQ14
        OPT_RECEIVE_INDICATOR_N:  auxiliaryPinBusOut[i] = rxStretch == 16'h0000;   // RQ14
        OPT_TRAFFIC_INDICATOR_N:
          auxiliaryPinBusOut[i] = (txStretch == 16'h0000) && (rxStretch == 16'h0000);  // RQ14
        OPT_CLOCK_OUT_THIRTY:     auxiliaryPinBusOut[i] = clkOut[0];       // RQ15
        OPT_CLOCK_OUT_FIFTEEN:    auxiliaryPinBusOut[i] = clkOut[1];       // RQ15
        OPT_CLOCK_OUT_SEVEN_HALF: auxiliaryPinBusOut[i] = clkOut[2];       // RQ15
        OPT_GPIO:
        begin
          if (mode != MODE_SERIAL || GPIO_SERIAL_MASK[i])   // RQ17
          begin
            auxiliaryPinBusOut[i] = gpioOut[i];
            auxiliaryPinBusOe[i]  = loaded && gpioOe[i];
          end
          else
          begin
            auxiliaryPinBusOe[i]     = 1'b0;
            auxiliaryPinBusPullup[i] = 1'b1;
          end
        end
        default:
        begin
          auxiliaryPinBusOe[i]     = 1'b0;          // RQ16
          auxiliaryPinBusPullup[i] = 1'b1;
        end
      endcase
    end
  end

endmodule : bridge_pin_function_select

// file: hdl/bridge_pkg.sv
package bridge_pkg;

  // clock and pin counts
  localparam int CLK_MHZ  = 100;
  localparam int AUX_PINS = 11;
  localparam int OPT_W    = 4;

  // interface modes held in configuration memory
  typedef enum logic [1:0]
  {
    MODE_SERIAL      = 2'h0,
    MODE_CPU_FIFO    = 2'h1,
    MODE_HALF_DUPLEX = 2'h2
  } mode_t;

  // auxiliary pin options, one per pin
  typedef enum logic [3:0]
  {
    OPT_PULLED_UP_INPUT      = 4'h0,
    OPT_DRIVE_HIGH           = 4'h1,
    OPT_DRIVE_LOW            = 4'h2,
    OPT_RS485_TX_ENABLE      = 4'h3,
    OPT_POWER_ENABLE_N       = 4'h4,
    OPT_TRANSMIT_INDICATOR_N = 4'h5,
    OPT_RECEIVE_INDICATOR_N  = 4'h6,
    OPT_TRAFFIC_INDICATOR_N  = 4'h7,
    OPT_SUSPEND_N            = 4'h8,
    OPT_CLOCK_OUT_THIRTY     = 4'h9,
    OPT_CLOCK_OUT_FIFTEEN    = 4'hA,
    OPT_CLOCK_OUT_SEVEN_HALF = 4'hB,
    OPT_GPIO                 = 4'hC
  } aux_opt_t;

  // pins usable as gpio while the serial port runs: 5, 6, 8, 9
  localparam logic [10:0] GPIO_SERIAL_MASK = 11'h360;

  // clock outputs, frequencies in kHz, half periods in cycles
  localparam int CLOCK_OUT_THIRTY_KHZ = 30000;
  localparam int CLOCK_OUT_FIFTEEN_KHZ = 15000;
  localparam int CLK7_KHZ  = 7500;
  localparam int HALF30    = (CLK_MHZ * 1000 / (2 * CLOCK_OUT_THIRTY_KHZ)) < 1 ? 1 : CLK_MHZ * 1000 / (2 * CLOCK_OUT_THIRTY_KHZ);
  localparam int HALF15    = (CLK_MHZ * 1000 / (2 * CLOCK_OUT_FIFTEEN_KHZ)) < 1 ? 1 : CLK_MHZ * 1000 / (2 * CLOCK_OUT_FIFTEEN_KHZ);
  localparam int HALF7     = (CLK_MHZ * 1000 / (2 * CLK7_KHZ)) < 1 ? 1 : CLK_MHZ * 1000 / (2 * CLK7_KHZ);

  // indicator pulse length
  localparam int INDICATOR_US     = 10;
  localparam int INDICATOR_CYCLES = INDICATOR_US * CLK_MHZ;

  // status byte fields (cpu mode, register select high)
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_RX_FULL  = 1;

  // host controller registers, byte offsets and fields
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_SEL_BIT = 2;
  localparam int CMD_W_LSB   = 4;
  localparam int CMD_D_LSB   = 8;
  localparam int ST_BUSY     = 0;
  localparam int ST_LINE     = 1;
  localparam int ST_D_LSB    = 8;

  // host operations
  localparam logic [1:0] OP_CPU_WRITE = 2'h0;
  localparam logic [1:0] OP_CPU_READ  = 2'h1;
  localparam logic [1:0] OP_HD_WRITE  = 2'h2;
  localparam logic [1:0] OP_HD_READ   = 2'h3;

  // host sequencer states, gray along the path
  typedef enum logic [1:0]
  {
    H_IDLE    = 2'b00,
    H_SETUP   = 2'b01,
    H_ACTIVE  = 2'b11,
    H_RELEASE = 2'b10
  } host_state_t;

  // beats per byte for width code 0..3 (1, 2, 4, 8 lines)
  function automatic logic [3:0] beatsOf(input logic [1:0] code);
    beatsOf = 4'(8 >> code);
  endfunction : beatsOf

  // lines in use for a width code
  function automatic logic [7:0] laneMask(input logic [1:0] code);
    laneMask = 8'((9'h001 << (4'h1 << code)) - 9'h001);
  endfunction : laneMask

  // lsb-first shift: new lines enter at the top
  function automatic logic [7:0] shiftIn(input logic [7:0] sr, input logic [7:0] lines, input logic [1:0] code);
    logic [3:0] w;
    w       = 4'(1 << code);
    shiftIn = 8'((sr >> w) | ((lines & laneMask(code)) << (4'h8 - w)));
  endfunction : shiftIn

endpackage : bridge_pkg

// file: hdl/bridge_pins_if.sv
`timescale 1ns/1ns
interface bridge_pins_if;
  logic [7:0] devData;
  logic [7:0] devDataOe;
  logic [7:0] hostData;
  logic [7:0] hostDataOe;
  logic [7:0] lowDataPins;
  logic       chipSelect_n;
  logic       registerSelectBit;
  logic       readStrobe_n;
  logic       writeStrobe_n;
  logic       serialClock;
  logic       slaveSelect_n;
  logic       statusLine;

  // wire level of the shared byte; undriven bits rest high
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      lowDataPins[i] = devDataOe[i] ? devData[i] : (hostDataOe[i] ? hostData[i] : 1'b1);
  end

  modport device (input lowDataPins, chipSelect_n, registerSelectBit, readStrobe_n, writeStrobe_n,
                  input serialClock, slaveSelect_n, output devData, devDataOe, statusLine);
  modport host (input lowDataPins, statusLine, output hostData, hostDataOe, chipSelect_n, registerSelectBit,
                output readStrobe_n, writeStrobe_n, serialClock, slaveSelect_n);
endinterface : bridge_pins_if

// file: hdl/bridge_host_master.sv
`timescale 1ns/1ns
module bridge_host_master
  import bridge_pkg::*;
#(
  parameter int HOST_DIV = 4
)
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // classic wishbone slave
  input  wire logic [3:0]  wbAdr,
  input  wire logic [31:0] wbDatIn,
  output logic [31:0]      wbDatOut,
  input  wire logic        wbWe,
  input  wire logic [3:0]  wbSel,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  output logic             wbAck,
  // link to the device
  bridge_pins_if.host      pins
);
  import bridge_pkg::*;

  host_state_t state;
  logic [7:0]  stepCnt;
  logic        step;
  logic        busy;
  logic [1:0]  op;
  logic        sel;
  logic [1:0]  width;
  logic [7:0]  data;
  logic [7:0]  result;
  logic [7:0]  sh;
  logic [4:0]  hdBeat;
  logic        isHdOp;
  logic        take;

  // step pulse paces every strobe, clock and release change; setup levels go out at once
  always_ff @(posedge clock)
  begin
    if (srst || state == H_IDLE || stepCnt == 8'(HOST_DIV - 1))
      stepCnt <= 8'h00;
    else
      stepCnt <= 8'(stepCnt + 8'h01);
  end
  assign step = (state != H_IDLE) && (stepCnt == 8'(HOST_DIV - 1));

  // bus answers one cycle after the request, every address acked
  always_ff @(posedge clock)
  begin
    if (srst)
      wbAck <= 1'b0;
    else
      wbAck <= wbCyc && wbStb && !wbAck;
  end
  assign take = wbCyc && wbStb && !wbAck && wbWe && wbAdr == REG_CMD && wbSel[0] && !busy;

  // read data registered; unmapped reads as zero
  always_ff @(posedge clock)
  begin
    if (srst)
      wbDatOut <= 32'h0000_0000;
    else if (wbAdr == REG_STATUS)
      wbDatOut <= 32'((result << ST_D_LSB) | (pins.statusLine << ST_LINE) | (busy << ST_BUSY));
    else
      wbDatOut <= 32'h0000_0000;
  end

  assign isHdOp = op[1];

  // sequencer for one cpu access or one half-duplex frame
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state <= H_IDLE;
      busy <= 1'b0;
      op <= OP_CPU_WRITE;
      sel <= 1'b0;
      width <= 2'h0;
      data <= 8'h00;
      result <= 8'h00;
      sh <= 8'h00;
      hdBeat <= 5'h00;
      pins.hostData <= 8'h00;
      pins.hostDataOe <= 8'h00;
      pins.chipSelect_n <= 1'b1;
      pins.registerSelectBit <= 1'b0;
      pins.readStrobe_n <= 1'b1;
      pins.writeStrobe_n <= 1'b1;
      pins.serialClock <= 1'b0;
      pins.slaveSelect_n <= 1'b1;
    end
    else
    case (state)
      H_IDLE:
        if (take)
        begin
          busy  <= 1'b1;
          op    <= wbDatIn[CMD_OP_LSB +: 2];
          sel   <= wbDatIn[CMD_SEL_BIT];
          width <= wbDatIn[CMD_W_LSB +: 2];
          data  <= wbSel[1] ? wbDatIn[CMD_D_LSB +: 8] : 8'h00;
          state <= H_SETUP;
        end
      H_SETUP:
      begin
        hdBeat <= 5'h00;
        if (isHdOp)
        begin
          pins.slaveSelect_n <= 1'b0;
          sh <= {7'h00, op == OP_HD_READ};
          pins.hostData <= {7'h00, op == OP_HD_READ};
          pins.hostDataOe <= laneMask(width);
        end
        else
        begin
          pins.chipSelect_n <= 1'b0;
          pins.registerSelectBit <= sel;
          pins.hostData <= data;
          pins.hostDataOe <= (op == OP_CPU_WRITE) ? 8'hFF : 8'h00;
        end
        if (step)
        begin
          state <= H_ACTIVE;
          pins.readStrobe_n <= !(op == OP_CPU_READ);
          pins.writeStrobe_n <= !(op == OP_CPU_WRITE);
          pins.serialClock <= isHdOp;
          hdBeat <= isHdOp ? 5'h01 : 5'h00;
        end
      end
      H_ACTIVE:
        if (step && !isHdOp)
        begin
          if (op == OP_CPU_READ)
            result <= pins.lowDataPins;
          pins.readStrobe_n <= 1'b1;
          pins.writeStrobe_n <= 1'b1;
          state <= H_RELEASE;
        end
        else if (step && !pins.serialClock)
        begin
          pins.serialClock <= 1'b1;
          hdBeat <= 5'(hdBeat + 5'h01);
          if (op == OP_HD_READ && hdBeat >= 5'(beatsOf(width)))
            result <= shiftIn(result, pins.lowDataPins, width);
        end
        else if (step)
        begin
          // clock low after every rise, the last one too, so high lasts one step
          pins.serialClock <= 1'b0;
          if (hdBeat == 5'(2 * beatsOf(width)))
            state <= H_RELEASE;
          else
          begin
            if (hdBeat == 5'(beatsOf(width)))
            begin
              sh <= data;
              pins.hostData <= data;
              if (op == OP_HD_READ)
                pins.hostDataOe <= 8'h00;   // turn the bus round before the device drives
            end
            else
            begin
              sh <= 8'(sh >> (4'(1 << width)));
              pins.hostData <= 8'(sh >> (4'(1 << width)));
            end
          end
        end
      H_RELEASE:
        if (step)
        begin
          pins.chipSelect_n <= 1'b1;
          pins.slaveSelect_n <= 1'b1;
          pins.serialClock <= 1'b0;
          pins.hostDataOe <= 8'h00;
          busy <= 1'b0;
          state <= H_IDLE;
        end
      default:
        state <= H_IDLE;
    endcase
  end

endmodule : bridge_host_master

// file: tb/bridge_link_props.sv
`timescale 1ns/1ns
// pin-level checks between the two design ends
module bridge_link_props
(
  // clock and reset
  input wire logic       clock,
  input wire logic       srst,
  // link signals
  input wire logic [7:0] devDataOe,
  input wire logic [7:0] hostDataOe,
  input wire logic       chipSelect_n,
  input wire logic       readStrobe_n,
  input wire logic       writeStrobe_n,
  input wire logic       serialClock,
  input wire logic       slaveSelect_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  // one direction at a time on the shared lines
  AST_ONE_DIRECTION: assert property ((devDataOe & hostDataOe) == 8'h00)
    else $error("both ends drive the data lines");
  AST_HOST_OE: assert property (hostDataOe != 8'h00 |-> !chipSelect_n || !slaveSelect_n)
    else $error("host drives data outside an access");
  // device lags ssel by up to two cycles
  AST_DEV_OE: assert property (devDataOe != 8'h00 |->
    (!chipSelect_n && !readStrobe_n) || !slaveSelect_n || !$past(slaveSelect_n) || !$past(slaveSelect_n, 2))
    else $error("device drives data unasked");
  AST_CS_QUAL: assert property ($fell(readStrobe_n) || $fell(writeStrobe_n) |-> !chipSelect_n)
    else $error("strobe without chip select");
  AST_CS_HOLD: assert property ($fell(chipSelect_n) |-> !chipSelect_n [*8])
    else $error("chip select too short");
  AST_WR_STEP: assert property ($fell(writeStrobe_n) |-> !writeStrobe_n [*4] ##1 writeStrobe_n)
    else $error("write strobe not one step");
  AST_RD_STEP: assert property ($fell(readStrobe_n) |-> !readStrobe_n [*4] ##1 readStrobe_n)
    else $error("read strobe not one step");
  AST_SCLK_STEP: assert property ($rose(serialClock) |-> serialClock [*4] ##1 !serialClock)
    else $error("serial clock high not one step");
  AST_SCLK_FRAME: assert property (serialClock |-> !slaveSelect_n)
    else $error("serial clock outside a frame");
endmodule : bridge_link_props

// file: tb/tb.sv
`timescale 1ns/1ns
module tb;
  import bridge_pkg::*;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [1:0]  cfgMode = 2'h1;
  logic [1:0]  cfgWidth = 2'h0;
  logic [43:0] cfgAux = 44'h79583C0C421;
  logic [7:0]  txData = 8'h00;
  logic        txLoad = 1'b0;
  logic        rxTake = 1'b0;
  logic        uartSending = 1'b0;
  logic        usbSuspend = 1'b0;
  logic [10:0] auxIn = 11'h000;
  logic [10:0] gpioOut = 11'h000;
  logic [10:0] gpioOe = 11'h000;
  logic [10:0] auxOut, auxOe, auxPu, gpioIn;
  logic [7:0]  rxData, d;
  logic        txEmpty, rxFull, wbAck, wbWe = 1'b0, wbCyc = 1'b0, wbStb = 1'b0;
  logic [3:0]  wbAdr = 4'h0;
  logic [31:0] wbDatIn = 32'h0, wbDatOut, q;
  int          err_total = 0;
  int          compares = 0;

  always #5 clock = ~clock;
  bridge_pins_if link();
  bridge_pin_function_select i_bridge_pin_function_select (.clock(clock), .srst(srst), .cfgMode(cfgMode),
    .cfgWidth(cfgWidth), .cfgAux(cfgAux), .txData(txData), .txLoad(txLoad), .txEmpty(txEmpty), .rxData(rxData),
    .rxFull(rxFull), .rxTake(rxTake), .uartSending(uartSending), .usbSuspend(usbSuspend),
    .auxiliaryPinBusIn(auxIn), .auxiliaryPinBusOut(auxOut), .auxiliaryPinBusOe(auxOe),
    .auxiliaryPinBusPullup(auxPu), .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioIn(gpioIn), .pins(link));
  bridge_host_master #(.HOST_DIV(4)) i_bridge_host_master (.clock(clock), .srst(srst), .wbAdr(wbAdr),
    .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbWe(wbWe), .wbSel(4'hF), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbAck(wbAck), .pins(link));
  bridge_link_props i_bridge_link_props (.clock(clock), .srst(srst), .devDataOe(link.devDataOe),
    .hostDataOe(link.hostDataOe), .chipSelect_n(link.chipSelect_n), .readStrobe_n(link.readStrobe_n),
    .writeStrobe_n(link.writeStrobe_n), .serialClock(link.serialClock), .slaveSelect_n(link.slaveSelect_n));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // one classic cycle; wait for ack however long it takes
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] dat);
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatIn <= dat;
    do
      @(posedge clock);
    while (wbAck !== 1'b1);
    q = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clock);
  endtask : wb

  // issue a link command, then poll until the host is idle
  task automatic xfer(input logic [1:0] op, input logic sel, input logic [7:0] dat);
    wb(1'b1, REG_CMD, {16'h0000, dat, 2'h0, cfgWidth, 1'b0, sel, op});
    do
      wb(1'b0, REG_STATUS, 32'h0);
    while (q[ST_BUSY] !== 1'b0);
  endtask : xfer

  // configuration is only taken after a reset
  task automatic rst(input logic [1:0] m, input logic [1:0] w);
    srst <= 1'b1;
    cfgMode <= m;
    cfgWidth <= w;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : rst

  initial
  begin
    #500000;
    err_total++;
    stop_test();
  end

  initial
  begin
    void'($urandom(3));
    // cpu fifo mode, then half duplex at widths 1, 2, 4, 8
    for (int k = 0; k < 5; k++)
    begin
      rst(k == 0 ? 2'h1 : 2'h2, 2'(k - 1));
      d = 8'($urandom);
      xfer(k == 0 ? OP_CPU_WRITE : OP_HD_WRITE, 1'b0, d);
      chk(32'({rxFull, rxData}), 32'({1'b1, d}));
      rxTake <= 1'b1;
      txData <= 8'($urandom);
      txLoad <= 1'b1;
      @(posedge clock);
      rxTake <= 1'b0;
      txLoad <= 1'b0;
      d = txData;
      xfer(k == 0 ? OP_CPU_READ : OP_HD_READ, 1'b0, 8'h00);
      chk(32'({txEmpty, q[15:8]}), 32'({1'b1, d}));
      if (k == 0)
        xfer(OP_CPU_READ, 1'b1, 8'h00);
      chk(k == 0 ? q[15:8] : 32'(q[ST_LINE]), 32'h1);
    end
    // auxiliary pin options
    rst(2'h1, 2'h0);
    d = 8'($urandom);
    gpioOut <= {11{d[0]}};
    gpioOe <= 11'h028;
    auxIn <= 11'($urandom);
    uartSending <= 1'b1;
    usbSuspend <= 1'b1;
    repeat (2) @(posedge clock);
    d[1] = auxOut[9];
    @(posedge clock);
    chk(32'(auxOut[9]), 32'(!d[1]));
    chk(32'({auxOut[10], auxOut[8]}), 32'h3);
    chk(32'(auxOe[6:0]), 32'h6F);
    chk(32'(auxOut[2:0]), 32'h5);
    chk(32'({auxOut[7], auxOut[6], auxPu[4]}), 32'h3);
    chk(32'({auxOut[5], auxOut[3]}), 32'({2{d[0]}}));
    chk(32'(gpioIn), 32'(auxIn));
    usbSuspend <= 1'b0;
    uartSending <= 1'b0;
    repeat (2) @(posedge clock);
    chk(32'({auxOut[7], auxOut[6], auxOut[2]}), 32'h4);
    // serial mode limits gpio; a later mode change is ignored
    rst(2'h0, 2'h0);
    cfgMode <= 2'h1;
    repeat (2) @(posedge clock);
    chk(32'({auxOe[5], auxOe[3]}), 32'h2);
    stop_test();
  end
endmodule : tb
